// [hw/mhp_host_port.sv]
// Host register port: ident, control/status, microcode pointer and window,
// plus the paint-processor interrupt flag and vectored interrupt request.
// Assumes host strobes are held until O_ACK and the microstore read data
// follows O_MS_ADDR within one clock.

module mhp_host_port (
  input wire logic I_CLOCK,
  input wire logic I_SRST,
  input wire logic [1:0] I_SEL,
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic I_LONG,
  input wire logic [15:0] I_WDATA,
  input wire logic I_IACK,
  input wire logic I_GB_ABSENT,
  input wire logic [3:0] I_VIEW_FLAGS,
  input wire logic [3:0] I_PAINT_FLAGS,
  input wire logic I_PAINT_ID_WR,
  input wire logic [mhp_pkg::VEC_W-1:0] I_PAINT_ID,
  input wire logic [mhp_pkg::WORD_W-1:0] I_MS_RDATA,
  output logic [15:0] O_RDATA,
  output logic O_ACK,
  output logic O_BERR,
  output logic O_IRQ,
  output logic O_VEC_VALID,
  output logic [mhp_pkg::VEC_W-1:0] O_VECTOR,
  output logic O_PAINT_PEND,
  output logic [mhp_pkg::MS_ADDR_W-1:0] O_MS_ADDR,
  output logic [1:0] O_MS_COL,
  output logic O_MS_WE,
  output logic [15:0] O_MS_WDATA,
  output logic O_BOARD_RST,
  output logic O_VIEW_RUN,
  output logic O_PAINT_RUN,
  output logic O_VIEW_FROM0,
  output logic O_PAINT_FROM0
);
  import mhp_pkg::*;

  typedef struct packed {
    mhp_state_t state;
    logic [15:0] rdata;
    logic ack;
    logic berr;
    logic pend;
    logic ien;
    logic irq;
    logic vec_valid;
    logic [VEC_W-1:0] vector;
    logic [15:0] pointer;
    logic [1:0] col;
    logic ms_we;
    logic [1:0] ms_col;
    logic [MS_ADDR_W-1:0] ms_addr;
    logic [15:0] ms_wdata;
    logic board_rst;
    logic [1:0] run;
    logic [1:0] from0;
    logic [1:0] cont_last;
    logic [1:0] halt_last;
  } mhp_port_t;

  mhp_port_t r;
  mhp_port_t nxt;
  logic [4:0] pins;
  logic rd_s;
  logic wr_s;
  logic long_s;
  logic iack_s;
  logic gb_s;
  logic [17:0] bus_s;
  logic [1:0] sel_s;
  logic [15:0] wdata_s;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  mhp_sync #(.W(5)) u_sync (
    .i_clock(I_CLOCK),
    .i_srst(I_SRST),
    .i_async({I_RD, I_WR, I_LONG, I_IACK, I_GB_ABSENT}),
    .o_sync(pins)
  );

  assign {rd_s, wr_s, long_s, iack_s, gb_s} = pins;

  // Select and data lines pass the same two stages as the strobes, so both
  // arrive together and no logic reads a pin that may still be moving.
  mhp_sync #(.W(18)) u_sync_bus (
    .i_clock(I_CLOCK),
    .i_srst(I_SRST),
    .i_async({I_SEL, I_WDATA}),
    .o_sync(bus_s)
  );

  assign {sel_s, wdata_s} = bus_s;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] sts;
    logic [1:0] ien_cmd;
    logic [2:0] pctl;
    logic cont_e;
    logic halt_e;
    logic set_pend;
    int p;
    p = 0;
    sts = '0;
    ien_cmd = IEN_KEEP;
    pctl = '0;
    cont_e = 1'b0;
    halt_e = 1'b0;
    set_pend = 1'b0;
    nxt = r;
    nxt.ack = 1'b0;
    nxt.berr = 1'b0;
    nxt.ms_we = 1'b0;
    nxt.from0 = 2'b00;

    sts[STS_PEND] = r.pend;
    sts[STS_IEN] = r.ien;
    sts[STS_COL_LSB +: 2] = r.col;
    sts[STS_ONE] = 1'b1;
    sts[STS_BOARD_RST] = r.board_rst;
    sts[STS_VIEW_RUN] = r.run[1];
    sts[STS_PAINT_RUN] = r.run[0];
    sts[STS_VIEW_FLG_LSB +: 4] = I_VIEW_FLAGS;
    sts[STS_PAINT_FLG_LSB +: 4] = I_PAINT_FLAGS;

    // Interrupt id load from the paint processor.
    if (I_PAINT_ID_WR) begin
      nxt.vector = I_PAINT_ID;
      if (!r.pend) begin
        set_pend = 1'b1;
        nxt.irq = r.ien;
      end
    end

    // Acknowledge cycle: vector is driven while the acknowledge stands.
    nxt.vec_valid = iack_s && (r.irq || r.vec_valid);
    if (iack_s && r.irq) begin
      nxt.irq = 1'b0;
    end

    unique case (r.state)
      MHP_IDLE: begin
        if (rd_s || wr_s) begin
          nxt.state = MHP_HOLD;
          if (long_s || (wr_s && sel_s == SEL_IDENT)) begin
            nxt.berr = 1'b1;
          end else begin
            nxt.ack = 1'b1;
            if (rd_s) begin
              unique case (sel_s)
                SEL_IDENT: nxt.rdata = {IDENT_UNUSED, IDENT_PATTERN, gb_s};
                SEL_CTRL_STATUS: nxt.rdata = sts;
                SEL_POINTER: nxt.rdata = r.pointer;
                SEL_WINDOW: begin
                  unique case (r.col)
                    2'h0: nxt.rdata = {8'h00, I_MS_RDATA[55:48]};
                    2'h1: nxt.rdata = I_MS_RDATA[47:32];
                    2'h2: nxt.rdata = I_MS_RDATA[31:16];
                    2'h3: nxt.rdata = I_MS_RDATA[15:0];
                  endcase
                end
              endcase
            end else begin
              unique case (sel_s)
                SEL_CTRL_STATUS: begin
                  if (wdata_s[CTL_CLR_PEND]) begin
                    nxt.pend = 1'b0;
                  end
                  ien_cmd = wdata_s[CTL_IEN_HI:CTL_IEN_LO];
                  unique case (ien_cmd)
                    IEN_KEEP: nxt.ien = r.ien;
                    IEN_ON: nxt.ien = 1'b1;
                    IEN_OFF: nxt.ien = 1'b0;
                    IEN_TOGGLE: nxt.ien = !r.ien;
                  endcase
                  nxt.board_rst = wdata_s[CTL_BOARD_RST];
                  for (p = 0; p < 2; p++) begin
                    pctl = (p == 1) ? wdata_s[CTL_VIEW_LSB +: 3] : wdata_s[CTL_PAINT_LSB +: 3];
                    cont_e = pctl[CTL_CONT_OFS] && !r.cont_last[p];
                    halt_e = pctl[CTL_HALT_OFS] && !r.halt_last[p];
                    nxt.cont_last[p] = pctl[CTL_CONT_OFS];
                    nxt.halt_last[p] = pctl[CTL_HALT_OFS];
                    if (cont_e && halt_e) begin
                      nxt.run[p] = !r.run[p];
                      nxt.from0[p] = !r.run[p] && pctl[CTL_FROM0_OFS];
                    end else if (cont_e) begin
                      nxt.run[p] = 1'b1;
                      nxt.from0[p] = pctl[CTL_FROM0_OFS];
                    end else if (halt_e) begin
                      nxt.run[p] = 1'b0;
                    end
                  end
                end
                SEL_POINTER: begin
                  nxt.pointer = wdata_s;
                  nxt.col = 2'h0;
                end
                SEL_WINDOW: begin
                  nxt.ms_we = 1'b1;
                  nxt.ms_col = r.col;
                  nxt.ms_wdata = (r.col == 2'h0) ? {8'h00, wdata_s[7:0]} : wdata_s;
                end
                default: nxt.berr = 1'b1;
              endcase
            end
            if (sel_s == SEL_WINDOW) begin
              nxt.col = r.col + 2'h1;
              if (r.col == COL_LAST) begin
                nxt.pointer = r.pointer + 16'h0001;
              end
            end
          end
        end
      end
      MHP_HOLD: begin
        if (!rd_s && !wr_s) begin
          nxt.state = MHP_IDLE;
        end
      end
    endcase

    // Disabling withdraws a request that has not yet been acknowledged.
    if (!nxt.ien) begin
      nxt.irq = 1'b0;
    end
    // A new event wins over a clear arriving in the same cycle.
    if (set_pend) begin
      nxt.pend = 1'b1;
    end
    // Holding the board reset keeps both processors halted.
    if (nxt.board_rst) begin
      nxt.ien = 1'b0;
      nxt.irq = 1'b0;
      nxt.run = 2'b00;
      nxt.from0 = 2'b00;
    end
    // The address follows the pointer one clock late, so a last-column write
    // still lands in its own word and not in the one after it.
    nxt.ms_addr = r.pointer[MS_ADDR_W-1:0];
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      r <= '0;
      r.state <= MHP_IDLE;
      r.pointer <= POINTER_RST;
      r.vector <= VECTOR_RST;
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_RDATA = r.rdata;
  assign O_ACK = r.ack;
  assign O_BERR = r.berr;
  assign O_IRQ = r.irq;
  assign O_VEC_VALID = r.vec_valid;
  assign O_VECTOR = r.vector;
  assign O_PAINT_PEND = r.pend;
  assign O_MS_ADDR = r.ms_addr;
  assign O_MS_COL = r.ms_col;
  assign O_MS_WE = r.ms_we;
  assign O_MS_WDATA = r.ms_wdata;
  assign O_BOARD_RST = r.board_rst;
  assign O_VIEW_RUN = r.run[1];
  assign O_PAINT_RUN = r.run[0];
  assign O_VIEW_FROM0 = r.from0[1];
  assign O_PAINT_FROM0 = r.from0[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic host_acc;
  assign host_acc = (r.state == MHP_IDLE) && (rd_s || wr_s) && !long_s;

  AST_PEND_SET: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_PAINT_ID_WR && !r.pend |=> r.pend)
    else $error("pending flag not set by id load");

  AST_IRQ_CAUSE: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    $rose(r.irq) |-> $past(I_PAINT_ID_WR) && !$past(r.pend) && $past(r.ien))
    else $error("interrupt request without enabled new event");

  AST_ID_REPLACE: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_PAINT_ID_WR && r.pend |=> !$rose(r.irq) && r.vector == $past(I_PAINT_ID))
    else $error("id load while pending misbehaved");

  AST_PTR_COL0: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    host_acc && wr_s && sel_s == SEL_POINTER |=> r.col == 2'h0 && r.ack)
    else $error("cursor not cleared by pointer write");

  AST_WRAP: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    host_acc && sel_s == SEL_WINDOW && r.col == COL_LAST
      |=> r.col == 2'h0 && r.pointer == $past(r.pointer) + 16'h0001)
    else $error("no wrap and increment after last column");

  AST_WIN_ADDR: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    host_acc && wr_s && sel_s == SEL_WINDOW
      |=> r.ms_we && r.ms_addr == $past(r.pointer[MS_ADDR_W-1:0]))
    else $error("window write not aimed at the selected word");

  AST_IEN_TOGGLE: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    host_acc && wr_s && sel_s == SEL_CTRL_STATUS
      && wdata_s[CTL_IEN_HI:CTL_IEN_LO] == IEN_TOGGLE
      && !wdata_s[CTL_BOARD_RST] |=> r.ien != $past(r.ien))
    else $error("enable toggle failed");

  AST_BOARD_RST: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    r.board_rst |-> !r.ien && r.run == 2'b00 && !r.irq)
    else $error("board reset left interrupts or processors active");

  AST_STATUS_READ: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    host_acc && rd_s && sel_s == SEL_CTRL_STATUS
      |=> O_RDATA[STS_PEND] == $past(r.pend) && O_RDATA[STS_IEN] == $past(r.ien))
    else $error("status flags read back wrong");

  AST_IEN_KEPT: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    iack_s && r.irq && !host_acc && !r.board_rst |=> r.ien && O_VEC_VALID)
    else $error("acknowledge disturbed enable or vector");

endmodule // mhp_host_port

// [hw/mhp_pkg.sv]
// Constants for the microstore host port and its interrupt logic.
// Assumes a single 20 MHz board clock and host strobes arriving from pins.
// Functional notes
// - Status shows pending interrupt flag.
// - Status shows interrupt enable state.
// - Column cursor shown; cleared on pointer write.
// - Status echoes board reset bit; reset halts board.
// - Status shows run/halt per processor.
// - Status shows four flags per processor.
// - Pointer bit 15 stored, not used to address.
// - Window accesses reach the selected microword.
// - Columns map 55:48, 47:32, 31:16, 15:0.
// - Pointer increments after fourth column.
// - Interrupt id write sets clear pending flag.
// - Host and paint processor share pending bit.
// - Disabled at set means no interrupt cycle.
// - Enabled at set starts cycle, id as vector.
// - Servicing leaves interrupt enable unchanged.
// - Id write while pending only replaces vector.
// - Enable command: keep, on, off, toggle.
// - Board reset disables interrupts, halts processors.
// - Select 01: status on read, control on write.

package mhp_pkg;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_IDENT = 2'h0;
  localparam logic [1:0] SEL_CTRL_STATUS = 2'h1;
  localparam logic [1:0] SEL_POINTER = 2'h2;
  localparam logic [1:0] SEL_WINDOW = 2'h3;

  // ----------------------------------------------------------------
  // Control register fields (write only)
  // ----------------------------------------------------------------
  localparam int CTL_CLR_PEND = 15;
  localparam int CTL_IEN_HI = 13;
  localparam int CTL_IEN_LO = 12;
  localparam int CTL_BOARD_RST = 8;
  localparam int CTL_VIEW_LSB = 3;
  localparam int CTL_PAINT_LSB = 0;
  localparam int CTL_FROM0_OFS = 2;
  localparam int CTL_HALT_OFS = 1;
  localparam int CTL_CONT_OFS = 0;
  localparam logic [1:0] IEN_KEEP = 2'h0;
  localparam logic [1:0] IEN_ON = 2'h1;
  localparam logic [1:0] IEN_OFF = 2'h2;
  localparam logic [1:0] IEN_TOGGLE = 2'h3;

  // ----------------------------------------------------------------
  // Status register fields (read only)
  // ----------------------------------------------------------------
  localparam int STS_PEND = 15;
  localparam int STS_IEN = 14;
  localparam int STS_COL_LSB = 12;
  localparam int STS_ONE = 11;
  localparam int STS_BOARD_RST = 10;
  localparam int STS_VIEW_RUN = 9;
  localparam int STS_PAINT_RUN = 8;
  localparam int STS_VIEW_FLG_LSB = 4;
  localparam int STS_PAINT_FLG_LSB = 0;

  // ----------------------------------------------------------------
  // Microword layout and reset values
  // ----------------------------------------------------------------
  localparam int WORD_W = 56;
  localparam int MS_ADDR_W = 15;
  localparam int VEC_W = 8;
  localparam logic [1:0] COL_LAST = 2'h3;
  localparam logic [15:0] POINTER_RST = 16'h0000;
  localparam logic [VEC_W-1:0] VECTOR_RST = 8'h00;
  localparam logic [7:0] IDENT_UNUSED = 8'hff;
  // Identity pattern value is arbitrary.
  localparam logic [6:0] IDENT_PATTERN = 7'h2a;

  typedef enum logic [1:0] {
    MHP_IDLE = 2'b01,
    MHP_HOLD = 2'b10
  } mhp_state_t;

endpackage : mhp_pkg

// [hw/mhp_sync.sv]
// Two-stage synchroniser for host pins.
// Assumes inputs are asynchronous to I_CLOCK; only stage two is read.

module mhp_sync #(
  parameter int W = 4
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } mhp_sync_t;

  mhp_sync_t r;
  mhp_sync_t nxt;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_comb begin
    nxt.meta = i_async;
    nxt.stable = r.meta;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign o_sync = r.stable;

endmodule // mhp_sync

// [sim/mhp_host_model.sv]
// Behavioural host bus master that drives the host pins of the port.
// Assumes the bench calls its tasks and that one clock serves both sides.
module mhp_host_model (
  input wire logic i_clock,
  input wire logic i_ack,
  input wire logic i_berr,
  input wire logic i_vec_valid,
  input wire logic [7:0] i_vector,
  input wire logic [15:0] i_rdata,
  output logic [1:0] o_sel,
  output logic o_rd,
  output logic o_wr,
  output logic o_long,
  output logic [15:0] o_wdata,
  output logic o_iack
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sel = 2'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_long = 1'b0;
    o_wdata = 16'h0000;
    o_iack = 1'b0;
  end
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Everything is held until the answer; released select and data lines show the inverse so stale data never
  // passes for a fresh value.
  task automatic access(input logic w, input logic [1:0] s, input logic [15:0] v,
                        input logic l, output logic [15:0] rd, output logic be);
    int n;
    n = 0;
    @(posedge i_clock);
    o_sel <= s;
    o_wdata <= v;
    o_long <= l;
    o_wr <= w;
    o_rd <= ~w;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_ack !== 1'b1 && i_berr !== 1'b1 && n < 20);
    rd = i_rdata;
    be = (i_berr === 1'b1) || (n >= 20);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_long <= 1'b0;
    o_wdata <= ~v;
    o_sel <= ~s;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic ack_irq(output logic [7:0] v);
    int n;
    n = 0;
    @(posedge i_clock);
    o_iack <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_vec_valid !== 1'b1 && n < 20);
    v = (n < 20) ? i_vector : ~i_vector;
    o_iack <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
endmodule // mhp_host_model

// [sim/tb_mhp_host_port.sv]
// Self-checking bench for the host port, with a host model and a microstore image.
// Assumes the design package is compiled first and a single 20 MHz clock.
module tb_mhp_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  import mhp_pkg::*;
  logic clk, srst, gb, id_wr, rd_s, wr_s, long_s, iack, be, any;
  logic ack, berr, irq, vec_valid, pend, ms_we, brst, vrun, prun, vf0, pf0;
  logic [1:0] f0;
  logic [3:0] vflags;
  logic [3:0] pflags;
  logic [7:0] id_v;
  logic [7:0] vector;
  logic [7:0] vs;
  logic [55:0] ms_rdata;
  logic [55:0] mem [0:31];
  logic [1:0] sel;
  logic [1:0] ms_col;
  logic [14:0] ms_addr;
  logic [15:0] wdata, rdata, ms_wdata, d;
  logic [31:0] seed;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  mhp_host_port dut_u (.I_CLOCK(clk), .I_SRST(srst), .I_SEL(sel), .I_RD(rd_s), .I_WR(wr_s),
    .I_LONG(long_s), .I_WDATA(wdata), .I_IACK(iack), .I_GB_ABSENT(gb),
    .I_VIEW_FLAGS(vflags), .I_PAINT_FLAGS(pflags), .I_PAINT_ID_WR(id_wr), .I_PAINT_ID(id_v),
    .I_MS_RDATA(ms_rdata), .O_RDATA(rdata), .O_ACK(ack), .O_BERR(berr), .O_IRQ(irq),
    .O_VEC_VALID(vec_valid), .O_VECTOR(vector), .O_PAINT_PEND(pend), .O_MS_ADDR(ms_addr),
    .O_MS_COL(ms_col), .O_MS_WE(ms_we), .O_MS_WDATA(ms_wdata), .O_BOARD_RST(brst),
    .O_VIEW_RUN(vrun), .O_PAINT_RUN(prun), .O_VIEW_FROM0(vf0), .O_PAINT_FROM0(pf0));
  mhp_host_model host_u (.i_clock(clk), .i_ack(ack), .i_berr(berr), .i_vec_valid(vec_valid),
    .i_vector(vector), .i_rdata(rdata), .o_sel(sel), .o_rd(rd_s), .o_wr(wr_s),
    .o_long(long_s), .o_wdata(wdata), .o_iack(iack));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Microstore image and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (ms_we === 1'b1) begin
      case (ms_col)
        2'h0: mem[ms_addr[4:0]][55:48] <= ms_wdata[7:0];
        2'h1: mem[ms_addr[4:0]][47:32] <= ms_wdata;
        2'h2: mem[ms_addr[4:0]][31:16] <= ms_wdata;
        default: mem[ms_addr[4:0]][15:0] <= ms_wdata;
      endcase
    end
    ms_rdata <= mem[ms_addr[4:0]];
    cyc <= cyc + 1;
    // Start-from-zero is a one-cycle pulse, so it is caught in a sticky copy.
    f0 <= srst ? 2'b00 : (f0 | {vf0, pf0});
    if (cyc == 6000) begin
      errors = errors + 1;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] colv(input logic [55:0] m, input logic [1:0] c);
    case (c)
      2'h0: return {8'h00, m[55:48]};
      2'h1: return m[47:32];
      2'h2: return m[31:16];
      default: return m[15:0];
    endcase
  endfunction
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d checks, %0d errors", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] v, input logic l);
    host_u.access(w, s, v, l, d, be);
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] v);
    acc(1'b1, s, v, 1'b0);
    check(be, 1'b0);
  endtask
  task automatic rd(input logic [1:0] s);
    acc(1'b0, s, 16'h0000, 1'b0);
    check(be, 1'b0);
  endtask
  // Fresh random flags before each status read, so a stuck flag field shows.
  task automatic sts(input logic p, input logic ie, input logic [1:0] c, input logic r,
                     input logic vr, input logic pr);
    logic [31:0] t;
    t = rnd();
    @(posedge clk);
    vflags <= t[3:0];
    pflags <= t[7:4];
    rd(SEL_CTRL_STATUS);
    check(d, {p, ie, c, 1'b1, r, vr, pr, t[3:0], t[7:4]});
  endtask
  task automatic watch();
    any = 1'b0;
    repeat (6) begin
      @(posedge clk);
      any = any | irq;
    end
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    id_wr <= 1'b1;
    id_v <= v;
    @(posedge clk);
    id_wr <= 1'b0;
    id_v <= ~v;
    watch();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] w;
    logic [55:0] img [0:1];
    logic [1:0] cmd [0:4];
    logic ie;
    seed = 32'h0000_000a;
    srst = 1'b1;
    gb = 1'b0;
    vflags = 4'h0;
    pflags = 4'h0;
    id_wr = 1'b0;
    id_v = 8'h00;
    ms_rdata = '0;
    for (int i = 0; i < 32; i++) mem[i] = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    w = rnd();
    gb <= w[0];
    sts(0, 0, 0, 0, 0, 0);
    rd(SEL_POINTER);
    check(d, 16'h0000);
    rd(SEL_IDENT);
    check(d, {IDENT_UNUSED, IDENT_PATTERN, w[0]});
    acc(1'b1, SEL_IDENT, 16'hffff, 1'b0);
    check(be, 1'b1);
    acc(1'b0, SEL_CTRL_STATUS, 16'h0000, 1'b1);
    check(be, 1'b1);
    acc(1'b1, SEL_POINTER, 16'h1234, 1'b1);
    check(be, 1'b1);
    rd(SEL_POINTER);
    check(d, 16'h0000);
    $display("test reset_and_refusals done");
    wr(SEL_POINTER, 16'h8003);
    check(ms_addr, 15'h0003);
    rd(SEL_POINTER);
    check(d, 16'h8003);
    wr(SEL_WINDOW, 16'h00a5);
    wr(SEL_WINDOW, 16'h5a5a);
    sts(0, 0, 2, 0, 0, 0);
    wr(SEL_POINTER, 16'h7fff);
    sts(0, 0, 0, 0, 0, 0);
    for (int k = 0; k < 2; k++) begin
      w = {rnd(), rnd()};
      img[k] = w[55:0];
      for (int c = 0; c < 4; c++) begin
        wr(SEL_WINDOW, colv(img[k], c[1:0]));
        sts(0, 0, (c == 3) ? 2'h0 : c[1:0] + 2'h1, 0, 0, 0);
      end
    end
    rd(SEL_POINTER);
    check(d, 16'h8001);
    check(mem[31], img[0]);
    check(mem[0], img[1]);
    wr(SEL_POINTER, 16'h7fff);
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 4; c++) begin
        rd(SEL_WINDOW);
        check(d, colv(img[k], c[1:0]));
      end
    end
    $display("test microstore done");
    cmd = '{IEN_ON, IEN_KEEP, IEN_TOGGLE, IEN_TOGGLE, IEN_OFF};
    ie = 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(SEL_CTRL_STATUS, {2'b00, cmd[i], 12'h000});
      ie = (cmd[i] == IEN_ON) | ((cmd[i] == IEN_KEEP) & ie) | ((cmd[i] == IEN_TOGGLE) & ~ie);
      sts(0, ie, 0, 0, 0, 0);
    end
    $display("test enable_commands done");
    wr(SEL_CTRL_STATUS, 16'h1000);
    w = rnd();
    pulse(w[7:0]);
    check({any, irq, pend}, 3'b111);
    host_u.ack_irq(vs);
    check(vs, w[7:0]);
    check(irq, 1'b0);
    pulse(w[15:8]);
    check({any, vector}, {1'b0, w[15:8]});
    sts(1, 1, 0, 0, 0, 0);
    wr(SEL_CTRL_STATUS, 16'h8000);
    sts(0, 1, 0, 0, 0, 0);
    wr(SEL_CTRL_STATUS, 16'h2000);
    pulse(w[23:16]);
    check({any, pend}, 2'b01);
    wr(SEL_CTRL_STATUS, 16'h1000);
    watch();
    check(any, 1'b0);
    sts(1, 1, 0, 0, 0, 0);
    wr(SEL_CTRL_STATUS, 16'h8000);
    sts(0, 1, 0, 0, 0, 0);
    pulse(w[31:24]);
    check(irq, 1'b1);
    wr(SEL_CTRL_STATUS, 16'ha000);
    check({irq, pend}, 2'b00);
    wr(SEL_CTRL_STATUS, 16'h1000);
    watch();
    check(any, 1'b0);
    $display("test interrupts done");
    wr(SEL_CTRL_STATUS, 16'h1009);
    sts(0, 1, 0, 0, 1, 1);
    check({vrun, prun}, 2'b11);
    wr(SEL_CTRL_STATUS, 16'h0100);
    sts(0, 0, 0, 1, 0, 0);
    check(brst, 1'b1);
    wr(SEL_CTRL_STATUS, 16'h0000);
    sts(0, 0, 0, 0, 0, 0);
    $display("test board_reset done");
    wr(SEL_CTRL_STATUS, 16'h003f);
    sts(0, 0, 0, 0, 1, 1);
    check(f0, 2'b11);
    wr(SEL_CTRL_STATUS, 16'h0000);
    wr(SEL_CTRL_STATUS, 16'h0012);
    sts(0, 0, 0, 0, 0, 0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(SEL_POINTER);
    check(d, 16'h0000);
    $display("test processor_control done");
    conclude();
  end
endmodule // tb_mhp_host_port
